/* File: rtl/dram_refresh_command_scheduler.sv */
// Purpose: decode refresh commands, keep bank and row counters, busy flags
// Assumes: command pins synchronous to sys_clk, two-edge command framing
// Notes:   controller keeps all timing and idle conditions

`timescale 1ns/1ps

module dram_refresh_command_scheduler #(
  parameter int NUM_BANKS = refresh_pkg::NUM_BANKS,
  parameter int ROW_W     = refresh_pkg::ROW_W,
  parameter int RFCAB_CYC = refresh_pkg::RFCAB_CYC,
  parameter int RFCPB_CYC = refresh_pkg::RFCPB_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire refresh_pkg::cmd_bus_t  cmd,
  input  wire logic                   self_refresh_exit,
  input  wire logic [NUM_BANKS-1:0]   bank_active,
  output refresh_pkg::ref_event_t     ref_event,
  output logic [2:0]                  bank_count,
  output logic [ROW_W-1:0]            row_count,
  output logic [NUM_BANKS-1:0]        bank_busy,
  output logic [NUM_BANKS-1:0]        bank_idle,
  output logic [ROW_W-1:0]            last_row,
  input  wire logic [2:0]             last_row_sel
);

  //--------------------------------------------------------------
  // command decode
  //--------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FIRST,
    ST_SECOND_PB,
    ST_SECOND_AB
  } dec_state_t;

  dec_state_t state;
  dec_state_t next_state;
  logic       ref_first;
  logic       pb_done;
  logic       ab_done;
  logic       after_ab;
  logic [2:0] pb_bank;

  function automatic logic is_refresh(refresh_pkg::cmd_bus_t c);
    return c.cs && !c.ca[0] && !c.ca[1] && !c.ca[2]
        && c.ca[3] && !c.ca[4];
  endfunction

  assign ref_first = (state == ST_FIRST) && is_refresh(cmd);
  assign pb_done   = (state == ST_SECOND_PB);
  assign ab_done   = (state == ST_SECOND_AB);
  assign pb_bank   = cmd.ca[2:0];

  always_comb begin
    next_state = state;
    case (state)
      ST_FIRST: begin
        if (ref_first) begin
          next_state = cmd.ca[5] ? ST_SECOND_AB : ST_SECOND_PB;
        end
      end
      ST_SECOND_PB: next_state = ST_FIRST;
      ST_SECOND_AB: next_state = ST_FIRST;
      default:      next_state = ST_FIRST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_FIRST;
    end else begin
      state <= next_state;
    end
  end

  //--------------------------------------------------------------
  // bank and row counters
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bank_count <= refresh_pkg::BANK_RESET;
    end else if (self_refresh_exit) begin
      bank_count <= refresh_pkg::BANK_RESET;
    end else if (ab_done) begin
      bank_count <= refresh_pkg::BANK_RESET;
    end else if (pb_done) begin
      bank_count <= bank_count + 3'h1;
    end
  end

  // flag: last refresh was all-bank, next one takes row plus one
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      after_ab <= 1'b0;
    end else if (ab_done) begin
      after_ab <= 1'b1;
    end else if (pb_done) begin
      after_ab <= 1'b0;
    end
  end

  logic [ROW_W-1:0] cur_row;
  assign cur_row = after_ab ? ROW_W'(row_count + 1'b1) : row_count;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      row_count <= refresh_pkg::ROW_RESET;
    end else if (ab_done) begin
      row_count <= cur_row;
    end else if (pb_done && bank_count == refresh_pkg::BANK_LAST) begin
      row_count <= ROW_W'(cur_row + 1'b1);
    end else if (pb_done) begin
      row_count <= cur_row;
    end
  end

  //--------------------------------------------------------------
  // event output
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ref_event <= '0;
    end else begin
      ref_event.valid <= pb_done || ab_done;
      ref_event.kind  <= pb_done ? refresh_pkg::REF_PER_BANK
                       : ab_done ? refresh_pkg::REF_ALL_BANK
                       : refresh_pkg::REF_NONE;
      ref_event.bank  <= pb_done ? pb_bank : 3'h0;
      ref_event.row   <= cur_row;
    end
  end

  //--------------------------------------------------------------
  // per-bank busy timers
  //--------------------------------------------------------------
  logic [refresh_pkg::TIMER_W-1:0] timer [NUM_BANKS];

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          timer[g] <= '0;
        end else if (ab_done) begin
          timer[g] <= refresh_pkg::TIMER_W'(RFCAB_CYC);
        end else if (pb_done && pb_bank == g) begin
          timer[g] <= refresh_pkg::TIMER_W'(RFCPB_CYC);
        end else if (timer[g] != '0) begin
          timer[g] <= timer[g] - 1'b1;
        end
      end
      assign bank_busy[g] = (timer[g] != '0);
      // idle once refresh finishes, unless controller holds it open
      assign bank_idle[g] = !bank_busy[g] && !bank_active[g];
    end
  endgenerate

  //--------------------------------------------------------------
  // last row per bank
  //--------------------------------------------------------------
  logic [2:0] wr_bank;
  assign wr_bank = pb_bank;

  row_store #(
    .DEPTH (NUM_BANKS),
    .AW    (3),
    .DW    (ROW_W)
  ) u_row_store (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (pb_done),
    .wr_addr (wr_bank),
    .wr_data (cur_row),
    .rd_addr (last_row_sel),
    .rd_data (last_row)
  );

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  a_ref_decode: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (state == ST_FIRST && is_refresh(cmd)) |=> (pb_done || ab_done))
    else $error("refresh not decoded");
  a_type_select: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ref_first && cmd.ca[5]) |=> ab_done)
    else $error("wrong refresh type");
  a_bank_capture: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    pb_done |=> (ref_event.bank == $past(cmd.ca[2:0])))
    else $error("bank not captured");
  a_bank_advance: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (pb_done && !self_refresh_exit) |=>
      bank_count == 3'($past(bank_count) + 3'h1))
    else $error("bank counter not advanced");
  a_srx_clear: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    self_refresh_exit |=> bank_count == 3'h0)
    else $error("bank counter not cleared on exit");
  a_ab_clear: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ab_done |=> bank_count == 3'h0)
    else $error("all-bank did not clear counter");
  a_ab_row: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ab_done && !after_ab) |=> ref_event.row == $past(row_count))
    else $error("all-bank row wrong");
  a_row_incr: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ((pb_done || ab_done) && after_ab) |=>
      ref_event.row == ROW_W'($past(row_count) + 1'b1))
    else $error("row not incremented after all-bank");
  a_busy_span: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (pb_done && !ab_done) |=> bank_busy[$past(pb_bank)])
    else $error("bank not busy after refresh");
  a_idle_after: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ab_done |-> ##(RFCAB_CYC + 1) (bank_busy == '0 ||
      $past(pb_done, 1) || $past(ab_done, 1)))
    else $error("banks not idle after all-bank");
  a_wrap_row: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (pb_done && bank_count == 3'h7 && !self_refresh_exit) |=>
      (bank_count == 3'h0 && row_count != $past(row_count)))
    else $error("wrap did not advance row");

  // command framing, event shape and counter behaviour
  a_pulse_width: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ref_event.valid |=> !ref_event.valid)
    else $error("event longer than one cycle");
  a_no_redecode: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (pb_done || ab_done) |=> !(pb_done || ab_done))
    else $error("second word decoded as command");
  a_pb_kind: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ref_first && !cmd.ca[5]) |=> pb_done)
    else $error("per-bank not selected");
  a_ab_kind: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ab_done |=> (ref_event.valid
      && ref_event.kind == refresh_pkg::REF_ALL_BANK))
    else $error("all-bank event kind wrong");
  a_count_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (!pb_done && !ab_done && !self_refresh_exit) |=> $stable(bank_count))
    else $error("bank counter moved without refresh");
  a_row_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (!pb_done && !ab_done) |=> $stable(row_count))
    else $error("row counter moved without refresh");
  a_mid_set: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (pb_done && !after_ab && bank_count != 3'h7) |=> $stable(row_count))
    else $error("row advanced inside a set");
  a_ab_nonzero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (ab_done && bank_count != 3'h0 && !after_ab) |=>
      (bank_count == 3'h0 && ref_event.row == $past(row_count)))
    else $error("all-bank from mid-set wrong");

  //--------------------------------------------------------------
  // per-bank busy checks
  //--------------------------------------------------------------
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank_chk
      a_pb_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (timer[g] == refresh_pkg::TIMER_W'(1) && !ab_done
          && !(pb_done && pb_bank == g)) |=> !bank_busy[g])
        else $error("bank not idle at end");
      a_ab_busy: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ab_done |=> bank_busy[g])
        else $error("bank not busy after all-bank");
      a_other_bank: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (pb_done && pb_bank != g && timer[g] == '0) |=> !bank_busy[g])
        else $error("other bank disturbed by per-bank");
      a_busy_len: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (pb_done && pb_bank == g) |=>
          timer[g] == refresh_pkg::TIMER_W'(RFCPB_CYC))
        else $error("per-bank busy length wrong");
    end
  endgenerate

  //--------------------------------------------------------------
  // cover points
  //--------------------------------------------------------------
  c_per_bank: cover property (@(posedge sys_clk) disable iff (!rstn) pb_done);
  c_all_bank: cover property (@(posedge sys_clk) disable iff (!rstn) ab_done);
  c_wrap:     cover property (@(posedge sys_clk) disable iff (!rstn)
    pb_done && bank_count == 3'h7);
  c_ab_then:  cover property (@(posedge sys_clk) disable iff (!rstn)
    ab_done ##[1:20] pb_done);
  c_srx_mid:  cover property (@(posedge sys_clk) disable iff (!rstn)
    self_refresh_exit && bank_count != 3'h0);

endmodule

/* File: rtl/refresh_pkg.sv */
// Purpose: shared constants and types for the refresh command scheduler
// Assumes: single sys_clk domain, synchronous active-low reset
// Notes:   command/address pins sampled on sys_clk rising edge
//
// Overview of operation
// - refresh seen when select high, CA0-2 and CA4 low, CA3 high
// - CA5 at first edge: low per-bank, high all-bank refresh
// - per-bank target bank taken from CA2..CA0 at second edge
// - count of eight starts at first per-bank after sync; each advances
// - bank counter cleared on reset and on every self-refresh exit
// - all-bank refresh resynchronises bank counter to zero
// - all-bank with nonzero counter clears it, refreshes at row counter
// - any refresh after an all-bank uses row counter plus one
// - refreshed bank inaccessible during tRFCpb; others stay usable
// - bank left idle when its per-bank refresh completes, unless bank_active holds it open
// - all banks left idle when all-bank refresh completes, except those bank_active holds open

package refresh_pkg;

  localparam int          NUM_BANKS     = 8;
  localparam int          BANK_W        = 3;
  localparam int          ROW_W         = 16;
  localparam logic [2:0]  BANK_RESET    = 3'h0;
  localparam logic [2:0]  BANK_LAST     = 3'h7;
  localparam logic [15:0] ROW_RESET     = 16'h0000;
  // refresh cycle times in ns, default figures of plain value
  localparam int          T_RFCAB_NS    = 280;
  localparam int          T_RFCPB_NS    = 140;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          RFCAB_CYC     =
    (T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RFCPB_CYC     =
    (T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_W       = 8;

  typedef enum logic [1:0] {
    REF_NONE,
    REF_PER_BANK,
    REF_ALL_BANK
  } ref_kind_t;

  typedef struct packed {
    logic       cs;
    logic [5:0] ca;
  } cmd_bus_t;

  typedef struct packed {
    logic                    valid;
    ref_kind_t               kind;
    logic [2:0]              bank;
    logic [15:0]             row;
  } ref_event_t;

endpackage

/* File: rtl/row_store.sv */
// Purpose: small per-bank memory of the last refreshed row
// Assumes: one write port, one read port, registered read data
// Notes:   used to report the row each bank last saw in a per-bank refresh

`timescale 1ns/1ps

module row_store #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int DW    = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: test/refresh_ctrl_model.sv */
// Purpose: controller stand-in that issues refresh commands on cmd
// Assumes: driven at the falling edge of sys_clk
// Notes:   idle select low, address lines toggle between commands

`timescale 1ns/1ps

module refresh_ctrl_model (
  input  wire logic             sys_clk,
  output refresh_pkg::cmd_bus_t cmd
);
  initial begin
    cmd = '{cs: 1'b0, ca: 6'h2A};
  end

  // -------------------------------------------------------------
  // two-word refresh command
  // -------------------------------------------------------------
  task automatic issue(input logic ab, input logic [2:0] bank);
    // separation before every refresh
    repeat (2) @(negedge sys_clk);
    cmd = '{cs: 1'b1, ca: {ab, 5'h08}};
    @(negedge sys_clk);
    cmd = '{cs: 1'b0, ca: {3'h5, bank}};
    @(negedge sys_clk);
    cmd = '{cs: 1'b0, ca: ~cmd.ca};
  endtask
endmodule

/* File: test/tb_dram_refresh_command_scheduler.sv */
// Purpose: self-checking bench for the refresh command scheduler
// Assumes: default cycle counts, inputs change at the falling edge
// Notes:   expected counters are tracked beside the design

`timescale 1ns/1ps

`define CHK(got, exp, msg) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("unexpected t=%0t %s", $time, msg); \
  end \
end

module tb_dram_refresh_command_scheduler;
  logic                    sys_clk = 1'b0;
  logic                    rstn = 1'b0;
  refresh_pkg::cmd_bus_t   cmd;
  logic                    self_refresh_exit = 1'b0;
  logic [7:0]              bank_active = 8'h00;
  refresh_pkg::ref_event_t ref_event;
  logic [2:0]              bank_count;
  logic [15:0]             row_count;
  logic [7:0]              bank_busy;
  logic [7:0]              bank_idle;
  logic [15:0]             last_row;
  logic [2:0]              last_row_sel = 3'h0;
  int                      err_total = 0;
  int                      checks_done = 0;
  int                      cycles = 0;
  logic [2:0]              exp_cnt;
  logic [15:0]             exp_row;
  logic                    after_ab;

  always #50 sys_clk = ~sys_clk;

  dram_refresh_command_scheduler u_dram_refresh_command_scheduler (
    .sys_clk(sys_clk), .rstn(rstn), .cmd(cmd),
    .self_refresh_exit(self_refresh_exit), .bank_active(bank_active),
    .ref_event(ref_event), .bank_count(bank_count),
    .row_count(row_count), .bank_busy(bank_busy),
    .bank_idle(bank_idle), .last_row(last_row),
    .last_row_sel(last_row_sel)
  );

  refresh_ctrl_model u_refresh_ctrl_model (
    .sys_clk(sys_clk), .cmd(cmd)
  );

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1500) begin
      err_total++;
      test_done();
    end
  end

  task automatic do_ref(input logic ab, input logic [2:0] b);
    logic [15:0] r;
    logic [7:0]  busy_exp;
    refresh_pkg::ref_kind_t kind_exp;
    // next bank up (b plus one, wrapping) open during per-bank, none during all-bank
    bank_active = ab ? 8'h00 : 8'h01 << (b + 3'h1);
    if (after_ab)
      exp_row = exp_row + 16'h0001;
    after_ab = ab;
    r = exp_row;
    exp_cnt = ab ? 3'h0 : exp_cnt + 3'h1;
    if (!ab && exp_cnt == 3'h0)
      exp_row = exp_row + 16'h0001;
    busy_exp = ab ? 8'hFF : 8'h01 << b;
    kind_exp = ab ? refresh_pkg::REF_ALL_BANK : refresh_pkg::REF_PER_BANK;
    u_refresh_ctrl_model.issue(ab, b);
    `CHK(ref_event.valid, 1'b1, "no event")
    `CHK(ref_event.kind, kind_exp, "kind")
    if (!ab) `CHK(ref_event.bank, b, "bank")
    `CHK(ref_event.row, r, "event row")
    `CHK(bank_count, exp_cnt, "bank count")
    `CHK(row_count, exp_row, "row count")
    `CHK(bank_busy, busy_exp, "busy")
    `CHK(bank_idle, ~busy_exp & ~bank_active, "idle")
    last_row_sel = b;
    @(negedge sys_clk);
    `CHK(ref_event.valid, 1'b0, "event width")
    if (!ab) `CHK(last_row, r, "last row")
    repeat (refresh_pkg::RFCAB_CYC) @(negedge sys_clk);
    `CHK(bank_idle, ~bank_active, "idle after")
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic test_reset();
    rstn = 1'b0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    exp_cnt = 3'h0;
    exp_row = 16'h0000;
    after_ab = 1'b0;
    `CHK(bank_count, 3'h0, "reset count")
    `CHK(row_count, 16'h0000, "reset row")
    `CHK(bank_busy, 8'h00, "reset busy")
    $display("test reset done");
  endtask

  task automatic test_wrap();
    logic [2:0] ord [8] = '{3'h1, 3'h3, 3'h0, 3'h2,
                            3'h4, 3'h7, 3'h5, 3'h6};
    foreach (ord[i])
      do_ref(1'b0, ord[i]);
    $display("test wrap done");
  endtask

  task automatic test_srx();
    do_ref(1'b0, 3'h2);
    do_ref(1'b0, 3'h5);
    self_refresh_exit = 1'b1;
    @(negedge sys_clk);
    self_refresh_exit = 1'b0;
    exp_cnt = 3'h0;
    `CHK(bank_count, 3'h0, "exit clear")
    do_ref(1'b0, 3'h5);
    $display("test self refresh exit done");
  endtask

  task automatic test_allbank();
    do_ref(1'b0, 3'h7);
    do_ref(1'b1, 3'h0);
    do_ref(1'b0, 3'h6);
    do_ref(1'b1, 3'h0);
    do_ref(1'b1, 3'h0);
    do_ref(1'b0, 3'h3);
    $display("test all-bank done");
  endtask

  initial begin
    test_reset();
    test_wrap();
    test_srx();
    test_allbank();
    test_reset();
    test_done();
  end
endmodule
